// >>> include/sbf_pkg.sv
/*
 Constants, register map, tag codes and state type for the sensor batch queue.
 Assumes one 100 MHz clock and an 8-bit register port with one-cycle read latency.
*/
package sbf_pkg;

    localparam int DEPTH      = 256;
    localparam int SLOTS      = 6;

    // Register offsets
    localparam logic [7:0] ADDR_EMB_EN   = 8'h05;
    localparam logic [7:0] ADDR_WM       = 8'h07;
    localparam logic [7:0] ADDR_CCTL     = 8'h08;
    localparam logic [7:0] ADDR_RATE     = 8'h09;
    localparam logic [7:0] ADDR_MODE     = 8'h0a;
    localparam logic [7:0] ADDR_IRQ1     = 8'h0d;
    localparam logic [7:0] ADDR_IRQ2     = 8'h0e;
    localparam logic [7:0] ADDR_STAT_LO  = 8'h1b;
    localparam logic [7:0] ADDR_STAT_HI  = 8'h1c;
    localparam logic [7:0] ADDR_BATCH_EN = 8'h44;
    localparam logic [7:0] ADDR_INIT     = 8'h67;
    localparam logic [7:0] ADDR_TAG      = 8'h78;
    localparam logic [7:0] ADDR_X_LOW    = 8'h79;
    localparam logic [7:0] ADDR_Z_HIGH   = 8'h7e;

    // Field positions
    localparam int CC_RAW_RATE_LSB = 1;
    localparam int CC_CFG_BIT      = 3;
    localparam int CC_XL2_BIT      = 4;
    localparam int CC_RT_COMP_BIT  = 6;
    localparam int CC_STOP_WM_BIT  = 7;
    localparam int EN_COMPRESS_BIT = 3;
    localparam int INIT_COMP_BIT   = 3;
    localparam int BE_EXT_BIT      = 6;
    localparam int IR_WM_BIT       = 0;
    localparam int IR_OVR_BIT      = 1;
    localparam int IR_FULL_BIT     = 2;
    localparam int ST_WM_BIT       = 7;
    localparam int ST_OVR_BIT      = 6;
    localparam int ST_FULL_BIT     = 5;

    // Forced raw word period base (8, 16, 32 samples)
    localparam logic [5:0] RAW_BASE = 6'h04;

    // Slot indices, lower wins the drain
    localparam logic [2:0] SLOT_XL  = 3'h0;
    localparam logic [2:0] SLOT_GY  = 3'h1;
    localparam logic [2:0] SLOT_XL2 = 3'h2;
    localparam logic [2:0] SLOT_HUB = 3'h3;
    localparam logic [2:0] SLOT_VRT = 3'h4;
    localparam logic [2:0] SLOT_CFG = 3'h5;

    // Tag sensor codes, upper five bits of tag byte
    localparam logic [4:0] TAG_GY      = 5'h01;
    localparam logic [4:0] TAG_XL      = 5'h02;
    localparam logic [4:0] TAG_XL_CMP  = 5'h07;
    localparam logic [4:0] TAG_GY_CMP  = 5'h08;
    localparam logic [4:0] TAG_CFG     = 5'h0e;
    localparam logic [4:0] TAG_HUB     = 5'h0f;
    localparam logic [4:0] TAG_VRT     = 5'h12;
    localparam logic [4:0] TAG_XL2     = 5'h1d;

    typedef enum logic [2:0] {
        MODE_BYPASS       = 3'b000,
        MODE_STOP_FULL    = 3'b001,
        MODE_CWTM_TO_FULL = 3'b010,
        MODE_CONT_TO_STOP = 3'b011,
        MODE_BYP_TO_CONT  = 3'b100,
        MODE_CONT         = 3'b110,
        MODE_BYP_TO_STOP  = 3'b111
    } sbf_mode_t;

    typedef struct packed {
        logic [DEPTH-1:0][55:0] mem;
        logic [7:0]             wr;
        logic [7:0]             rd;
        logic [8:0]             cnt;
        logic                   ovr;
        logic [5:0]             rmask;
        logic [7:0]             wm;
        logic [7:0]             cctl;
        logic [7:0]             rate;
        logic [7:0]             mode;
        logic [7:0]             irq1;
        logic [7:0]             irq2;
        logic [7:0]             emb_en;
        logic [7:0]             batch_en;
        logic                   trig;
        logic [SLOTS-1:0]       sv;
        logic [SLOTS-1:0][55:0] sw;
        logic [1:0][47:0]       refv;
        logic [1:0][47:0]       half;
        logic [1:0]             ref_ok;
        logic [1:0]             half_ok;
        logic [1:0][5:0]        rawc;
        logic [7:0]             rdata;
        logic                   irq1o;
        logic                   irq2o;
    } sbf_state_t;

endpackage : sbf_pkg

// >>> verilog/sbf_batch_queue.sv
/*
 Tagged batching queue: captures sensor samples into seven-byte words,
 optional 2:1 delta packing of accel/gyro, seven queue modes, watermark,
 full and overrun flags routed to two interrupt lines.
 Assumes all sources and the trigger are on i_ref_clk; register port is
 single-cycle strobes with read data one cycle later.
*/
`timescale 1ns/10ps
module sbf_batch_queue
    import sbf_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // Main sensors
    input  wire logic        i_xl_valid,
    input  wire logic [47:0] i_xl_data,
    input  wire logic        i_gy_valid,
    input  wire logic [47:0] i_gy_data,
    input  wire logic        i_xl2_valid,
    input  wire logic [47:0] i_xl2_data,
    input  wire logic        i_machine_batch_go,
    // Virtual and hub sources
    input  wire logic        i_hub_valid,
    input  wire logic [47:0] i_hub_data,
    input  wire logic        i_virt_valid,
    input  wire logic [2:0]  i_virt_kind,
    input  wire logic [47:0] i_virt_data,
    input  wire logic        i_fusion_running,
    // Mode trigger and interrupts
    input  wire logic        i_mode_trigger,
    output logic             o_irq1,
    output logic             o_irq2
);

    sbf_state_t s_q;
    sbf_state_t s_d;

    function automatic logic fits8(input logic [15:0] d);
        fits8 = (d[15:7] == 9'h000) || (d[15:7] == 9'h1ff);
    endfunction : fits8

    function automatic logic [55:0] mk_word(input logic [4:0] code, input logic [47:0] data);
        mk_word = {code, 3'h0, data};
    endfunction : mk_word

    always_comb begin
        logic             comp;
        logic [1:0]       frr;
        logic [5:0]       rlim;
        sbf_mode_t        md;
        logic             byp;
        logic             ovw;
        logic             cwtm_pre;
        logic [8:0]       limit;
        logic             full;
        logic             wm_hit;
        logic [47:0]      smp;
        logic             vld;
        logic             fit;
        logic             forced;
        logic [15:0]      dl1;
        logic [15:0]      dl2;
        logic [47:0]      pk1;
        logic [47:0]      pk2;
        logic [4:0]       traw;
        logic [4:0]       tcmp;
        logic [2:0]       pick;
        logic             have;
        logic [2:0]       bidx;
        logic             pop;
        logic             data_rd;
        logic [8:0]       cnt1;
        logic [7:0]       rd1;
        logic [7:0]       stat_hi;
        logic             vrt_ok;

        s_d      = s_q;
        comp     = s_q.emb_en[EN_COMPRESS_BIT] && s_q.cctl[CC_RT_COMP_BIT];
        frr      = s_q.cctl[CC_RAW_RATE_LSB +: 2];
        rlim     = 6'(RAW_BASE << frr);
        md       = sbf_mode_t'(s_q.mode[2:0]);
        smp      = '0;
        vld      = 1'b0;
        fit      = 1'b0;
        forced   = 1'b0;
        dl1      = '0;
        dl2      = '0;
        pk1      = '0;
        pk2      = '0;
        traw     = TAG_XL;
        tcmp     = TAG_XL_CMP;
        pick     = '0;
        have     = 1'b0;
        bidx     = 3'(i_reg_addr - ADDR_X_LOW);
        pop      = 1'b0;
        vrt_ok   = 1'b0;

        // Effective behaviour of the selected mode
        byp      = 1'b0;
        ovw      = 1'b0;
        cwtm_pre = 1'b0;
        unique case (md)
            MODE_BYPASS:       byp = 1'b1;
            MODE_STOP_FULL:    ovw = 1'b0;
            MODE_CONT:         ovw = 1'b1;
            MODE_CONT_TO_STOP: ovw = !s_q.trig;
            MODE_BYP_TO_CONT: begin
                byp = !s_q.trig;
                ovw = s_q.trig;
            end
            MODE_BYP_TO_STOP:  byp = !s_q.trig;
            MODE_CWTM_TO_FULL: begin
                ovw      = !s_q.trig;
                cwtm_pre = !s_q.trig;
            end
            default:           byp = 1'b1;
        endcase

        // Usable depth
        if ((s_q.cctl[CC_STOP_WM_BIT] || cwtm_pre) && s_q.wm != 8'h00) begin
            limit = {1'b0, s_q.wm};
        end else begin
            limit = 9'(DEPTH);
        end
        full   = s_q.cnt >= (limit - 9'h001);
        wm_hit = s_q.cnt >= {1'b0, s_q.wm};

        // Drain one slot per cycle, lowest index first
        for (int k = SLOTS - 1; k >= 0; k--) begin
            if (s_q.sv[k]) begin
                pick = 3'(k);
                have = 1'b1;
            end
        end
        if (have) begin
            s_d.sv[pick] = 1'b0;
        end

        // Accel and gyro capture with optional delta packing
        for (int c = 0; c < 2; c++) begin
            if (c == 0) begin
                smp  = i_xl_data;
                vld  = i_xl_valid && s_q.rate[3:0] != 4'h0;
                traw = TAG_XL;
                tcmp = TAG_XL_CMP;
            end else begin
                smp  = i_gy_data;
                vld  = i_gy_valid && s_q.rate[7:4] != 4'h0;
                traw = TAG_GY;
                tcmp = TAG_GY_CMP;
            end
            forced = frr != 2'h0 && s_q.rawc[c] >= (rlim - 6'h01);
            fit    = s_q.ref_ok[c];
            for (int k = 0; k < 3; k++) begin
                dl1 = s_q.half[c][16*k +: 16] - s_q.refv[c][16*k +: 16];
                dl2 = smp[16*k +: 16] - s_q.half[c][16*k +: 16];
                fit = fit && fits8(dl1) && fits8(dl2);
                pk1[8*k +: 8] = dl1[7:0];
                pk2[8*k +: 8] = dl2[7:0];
            end
            if (vld) begin
                s_d.sv[c] = 1'b1;
                if (!comp) begin
                    s_d.ref_ok[c] = 1'b0;
                    if (s_q.half_ok[c]) begin
                        s_d.sw[c]   = mk_word(traw, s_q.half[c]);
                        s_d.half[c] = smp;
                    end else begin
                        s_d.sw[c]   = mk_word(traw, smp);
                    end
                end else if (!s_q.half_ok[c]) begin
                    if (!s_q.ref_ok[c] || forced) begin
                        s_d.sw[c]     = mk_word(traw, smp);
                        s_d.refv[c]   = smp;
                        s_d.ref_ok[c] = 1'b1;
                        s_d.rawc[c]   = '0;
                    end else begin
                        s_d.sv[c]      = s_q.sv[c] && !(have && pick == 3'(c));
                        s_d.half[c]    = smp;
                        s_d.half_ok[c] = 1'b1;
                        s_d.rawc[c]    = s_q.rawc[c] + 6'h01;
                    end
                end else if (fit && !forced) begin
                    s_d.sw[c]      = mk_word(tcmp, {pk2[23:0], pk1[23:0]});
                    s_d.refv[c]    = smp;
                    s_d.half_ok[c] = 1'b0;
                    s_d.rawc[c]    = s_q.rawc[c] + 6'h01;
                end else begin
                    // First of the pair goes raw, second waits for a partner
                    s_d.sw[c]     = mk_word(traw, s_q.half[c]);
                    s_d.refv[c]   = s_q.half[c];
                    s_d.ref_ok[c] = 1'b1;
                    s_d.half[c]   = smp;
                    s_d.rawc[c]   = '0;
                end
            end else if (!comp && s_q.half_ok[c] && !s_d.sv[c]) begin
                // Flush a pending sample once packing is off
                s_d.sv[c]      = 1'b1;
                s_d.sw[c]      = mk_word(traw, s_q.half[c]);
                s_d.half_ok[c] = 1'b0;
            end
        end

        // Other sources
        if (i_xl2_valid && s_q.cctl[CC_XL2_BIT] && i_machine_batch_go) begin
            s_d.sv[SLOT_XL2] = 1'b1;
            s_d.sw[SLOT_XL2] = mk_word(TAG_XL2, i_xl2_data);
        end
        if (i_hub_valid && s_q.batch_en[BE_EXT_BIT]) begin
            s_d.sv[SLOT_HUB] = 1'b1;
            s_d.sw[SLOT_HUB] = mk_word(TAG_HUB, i_hub_data);
        end
        if (i_virt_kind < 3'h6) begin
            vrt_ok = s_q.batch_en[i_virt_kind] && (i_virt_kind < 3'h3 || i_fusion_running);
        end
        if (i_virt_valid && vrt_ok) begin
            s_d.sv[SLOT_VRT] = 1'b1;
            s_d.sw[SLOT_VRT] = mk_word(5'(TAG_VRT + 5'(i_virt_kind)), i_virt_data);
        end

        // Register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_WM:       s_d.wm = i_reg_wdata;
                ADDR_CCTL:     s_d.cctl = i_reg_wdata;
                ADDR_RATE:     s_d.rate = i_reg_wdata;
                ADDR_MODE: begin
                    s_d.mode = {5'h00, i_reg_wdata[2:0]};
                    s_d.trig = 1'b0;
                end
                ADDR_IRQ1:     s_d.irq1 = i_reg_wdata;
                ADDR_IRQ2:     s_d.irq2 = i_reg_wdata;
                ADDR_EMB_EN:   s_d.emb_en = i_reg_wdata;
                ADDR_BATCH_EN: s_d.batch_en = i_reg_wdata;
                ADDR_INIT: begin
                    if (i_reg_wdata[INIT_COMP_BIT]) begin
                        s_d.ref_ok = '0;
                        s_d.rawc   = '0;
                    end
                end
                default: ;
            endcase
            if ((i_reg_addr == ADDR_RATE || i_reg_addr == ADDR_CCTL) && s_q.cctl[CC_CFG_BIT]) begin
                s_d.sv[SLOT_CFG] = 1'b1;
                s_d.sw[SLOT_CFG] = mk_word(TAG_CFG, {32'h0, s_d.cctl, s_d.rate});
            end
        end

        // Trigger latches while in a two-phase mode
        if (i_mode_trigger && !(i_reg_wr && i_reg_addr == ADDR_MODE) &&
            (md == MODE_CONT_TO_STOP || md == MODE_BYP_TO_CONT ||
             md == MODE_BYP_TO_STOP || md == MODE_CWTM_TO_FULL)) begin
            s_d.trig = 1'b1;
        end

        // Host read of data bytes
        data_rd = i_reg_rd && i_reg_addr >= ADDR_X_LOW && i_reg_addr <= ADDR_Z_HIGH;
        if (data_rd && s_q.cnt != 9'h000) begin
            s_d.rmask[bidx] = 1'b1;
            if ((s_q.rmask | (6'h01 << bidx)) == 6'h3f && s_q.cnt != 9'h000) begin
                pop         = 1'b1;
                s_d.rmask   = '0;
            end
        end
        cnt1 = s_q.cnt - {8'h00, pop};
        rd1  = s_q.rd + {7'h00, pop};
        if (pop) begin
            s_d.ovr = 1'b0;
        end

        // Push drained word
        if (have) begin
            if (cnt1 < limit) begin
                s_d.mem[s_q.wr] = s_q.sw[pick];
                s_d.wr          = s_q.wr + 8'h01;
                cnt1            = cnt1 + 9'h001;
            end else if (ovw) begin
                s_d.mem[s_q.wr] = s_q.sw[pick];
                s_d.wr          = s_q.wr + 8'h01;
                rd1             = rd1 + 8'h01;
                s_d.rmask       = '0;
                s_d.ovr         = 1'b1;
            end
        end
        s_d.cnt = cnt1;
        s_d.rd  = rd1;

        // Bypass empties the queue and holds it empty
        if (byp) begin
            s_d.cnt   = '0;
            s_d.wr    = '0;
            s_d.rd    = '0;
            s_d.ovr   = 1'b0;
            s_d.rmask = '0;
        end

        // Status and read data
        stat_hi              = {7'h00, s_q.cnt[8]};
        stat_hi[ST_WM_BIT]   = wm_hit;
        stat_hi[ST_OVR_BIT]  = s_q.ovr;
        stat_hi[ST_FULL_BIT] = full;
        s_d.rdata = 8'h00;
        if (i_reg_rd) begin
            if (data_rd) begin
                if (s_q.cnt != 9'h000) begin
                    s_d.rdata = s_q.mem[s_q.rd][8*bidx +: 8];
                end
            end else begin
                case (i_reg_addr)
                    ADDR_WM:       s_d.rdata = s_q.wm;
                    ADDR_CCTL:     s_d.rdata = s_q.cctl;
                    ADDR_RATE:     s_d.rdata = s_q.rate;
                    ADDR_MODE:     s_d.rdata = s_q.mode;
                    ADDR_IRQ1:     s_d.rdata = s_q.irq1;
                    ADDR_IRQ2:     s_d.rdata = s_q.irq2;
                    ADDR_EMB_EN:   s_d.rdata = s_q.emb_en;
                    ADDR_BATCH_EN: s_d.rdata = s_q.batch_en;
                    ADDR_STAT_LO:  s_d.rdata = s_q.cnt[7:0];
                    ADDR_STAT_HI:  s_d.rdata = stat_hi;
                    ADDR_TAG:      s_d.rdata = (s_q.cnt != 9'h000) ? s_q.mem[s_q.rd][55:48] : 8'h00;
                    default:       s_d.rdata = 8'h00;
                endcase
            end
        end

        // Interrupt routing
        s_d.irq1o = (s_q.irq1[IR_WM_BIT] && wm_hit) || (s_q.irq1[IR_OVR_BIT] && s_q.ovr) ||
                    (s_q.irq1[IR_FULL_BIT] && full);
        s_d.irq2o = (s_q.irq2[IR_WM_BIT] && wm_hit) || (s_q.irq2[IR_OVR_BIT] && s_q.ovr) ||
                    (s_q.irq2[IR_FULL_BIT] && full);
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_irq1      = s_q.irq1o;
    assign o_irq2      = s_q.irq2o;

endmodule : sbf_batch_queue

// >>> dv/sbf_batch_queue_props.sv
/*
 Checker for the batch queue register port and interrupt lines.
 Assumes binding to the top module; shadows a few host-written registers.
*/
`timescale 1ns/10ps
module sbf_batch_queue_props
    import sbf_pkg::*;
(
    // Clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    // Sources and interrupts
    input wire logic       i_xl_valid,
    input wire logic       i_gy_valid,
    input wire logic       i_xl2_valid,
    input wire logic       i_hub_valid,
    input wire logic       i_virt_valid,
    input wire logic       o_irq1,
    input wire logic       o_irq2
);
    logic [7:0] irq1_q, irq2_q, wm_q, mode_q;
    logic       seen_q;
    logic       rd_hi, rd_out;
    assign rd_hi  = i_reg_rd && i_reg_addr == ADDR_STAT_HI;
    assign rd_out = i_reg_rd && i_reg_addr >= ADDR_TAG && i_reg_addr <= ADDR_Z_HIGH;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq1_q <= 8'h00;
            irq2_q <= 8'h00;
            wm_q   <= 8'h00;
            mode_q <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == ADDR_IRQ1) irq1_q <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == ADDR_IRQ2) irq2_q <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == ADDR_WM) wm_q <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == ADDR_MODE) mode_q <= i_reg_wdata;
            seen_q <= seen_q | i_xl_valid | i_gy_valid | i_xl2_valid | i_hub_valid | i_virt_valid;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_rdata_idle: assert property (
        o_reg_rdata != 8'h00 |-> $past(i_reg_rd)) else $error("read data without a read strobe");
    a_unmapped_zero: assert property (
        i_reg_rd && (i_reg_addr == 8'h00 || i_reg_addr == 8'hff) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq1_unrouted: assert property (
        (irq1_q[2:0] == 3'h0) [*3] |-> !o_irq1) else $error("irq1 high with no route");
    a_irq2_unrouted: assert property (
        (irq2_q[2:0] == 3'h0) [*3] |-> !o_irq2) else $error("irq2 high with no route");
    a_wm_zero_flag: assert property (
        (wm_q == 8'h00) [*3] ##0 rd_hi |=> o_reg_rdata[ST_WM_BIT]) else $error("watermark flag low at zero");
    a_empty_out_zero: assert property (
        !seen_q && rd_out |=> o_reg_rdata == 8'h00) else $error("empty queue output not zero");
    a_bypass_count: assert property (
        (mode_q[2:0] == 3'h0) [*3] ##0 (i_reg_rd && i_reg_addr == ADDR_STAT_LO) |=> o_reg_rdata == 8'h00)
        else $error("bypass count not zero");
    a_bypass_flags: assert property (
        (mode_q[2:0] == 3'h0) [*3] ##0 rd_hi |=> o_reg_rdata[6:5] == 2'b00) else $error("bypass flags set");
    c_irq1_up: cover property ($rose(o_irq1));
    c_full_read: cover property (rd_hi ##1 o_reg_rdata[ST_FULL_BIT]);
    c_ovr_read: cover property (rd_hi ##1 o_reg_rdata[ST_OVR_BIT]);
endmodule : sbf_batch_queue_props

// >>> dv/sbf_host_model.sv
/*
 Host processor model: one-cycle strobes on the register port.
 Assumes the bench calls its tasks; read data taken the cycle after the strobe.
*/
`timescale 1ns/10ps
module sbf_host_model
    import sbf_pkg::*;
(
    // Clock
    input  wire logic       i_ref_clk,
    // Register port
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd,
    input  wire logic [7:0] i_rdata
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr  <= a;
        o_wdata <= (a == ADDR_CCTL) ? d & 8'hef : d;
        o_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask : rd
endmodule : sbf_host_model

// >>> dv/tb.sv
/*
 Self-checking bench: host model on the register port, sources driven here,
 a queue model predicts words, counts, flags and interrupt lines.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb
    import sbf_pkg::*;
;
    localparam logic [7:0] RA [14] = '{ADDR_WM, ADDR_CCTL, ADDR_RATE, ADDR_MODE, ADDR_IRQ1, ADDR_IRQ2,
        ADDR_STAT_LO, ADDR_STAT_HI, ADDR_EMB_EN, ADDR_BATCH_EN, ADDR_TAG, ADDR_X_LOW, ADDR_Z_HIGH, 8'h00};
    localparam logic [7:0] RW [5] = '{ADDR_WM, ADDR_IRQ1, ADDR_IRQ2, ADDR_BATCH_EN, ADDR_EMB_EN};
    logic        clk, rst, wr, rd, fus, go, trig, irq1, irq2;
    logic [7:0]  addr, wdata, rdata, d8;
    logic [3:0]  sv;
    logic [2:0]  vk;
    logic [47:0] sd;
    logic [31:0] seed = 32'd87;
    logic [55:0] mq [$];
    logic [7:0]  m_wm, m_cctl, m_rate, m_mode, m_ben, m_irq1, m_irq2;
    logic        m_ovr;
    int          mismatches, n_checks;

    sbf_host_model sbf_host_model_inst (.i_ref_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata));
    sbf_batch_queue sbf_batch_queue_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_xl_valid(sv[0]),
        .i_xl_data(sd), .i_gy_valid(sv[1]), .i_gy_data(sd), .i_xl2_valid(1'b0), .i_xl2_data(sd),
        .i_machine_batch_go(go), .i_hub_valid(sv[2]), .i_hub_data(sd), .i_virt_valid(sv[3]),
        .i_virt_kind(vk), .i_virt_data(sd), .i_fusion_running(fus), .i_mode_trigger(trig),
        .o_irq1(irq1), .o_irq2(irq2));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic int lim();
        return (m_cctl[CC_STOP_WM_BIT] || m_mode[2:0] == 3'h2 && !trig) && m_wm != 0 ? int'(m_wm) : DEPTH;
    endfunction : lim
    task automatic mpush(input logic [4:0] code, input logic [47:0] d);
        if (m_mode[2:0] inside {3'h0, 3'h5} || !trig && m_mode[2:0] inside {3'h4, 3'h7}) return;
        if (mq.size() >= lim()) begin
            if (m_mode[2:0] inside {3'h1, 3'h7} || trig && m_mode[2:0] inside {3'h2, 3'h3}) return;
            void'(mq.pop_front());
            m_ovr = 1'b1;
        end
        mq.push_back({code, 3'h0, d});
    endtask : mpush
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic meta;
        meta = (a == ADDR_RATE || a == ADDR_CCTL) && m_cctl[CC_CFG_BIT];
        sbf_host_model_inst.wr(a, d);
        case (a)
            ADDR_WM:       m_wm = d;
            ADDR_CCTL:     m_cctl = d & 8'hef;
            ADDR_RATE:     m_rate = d;
            ADDR_MODE:     m_mode = d;
            ADDR_IRQ1:     m_irq1 = d;
            ADDR_IRQ2:     m_irq2 = d;
            ADDR_BATCH_EN: m_ben = d;
            default: ;
        endcase
        if (meta) mpush(TAG_CFG, {32'h0, m_cctl, m_rate});
        repeat (3) @(posedge clk);
    endtask : w
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        sbf_host_model_inst.rd(a, g);
        `CHK(g, e)
    endtask : chk_rd
    task automatic src(input int s, input logic [2:0] k);
        logic [47:0] d;
        logic        ok;
        d = {16'(xs()), xs()};
        @(posedge clk);
        sd <= d;
        vk <= k;
        sv <= 4'h1 << s;
        @(posedge clk);
        sv <= 4'h0;
        sd <= ~d;
        vk <= ~k;
        repeat (3) @(posedge clk);
        ok = (s == 0) ? m_rate[3:0] != 0 : (s == 1) ? m_rate[7:4] != 0 : (s == 2) ? m_ben[BE_EXT_BIT]
            : (k < 6 && m_ben[k] && (k < 3 || fus));
        if (ok) mpush((s == 0) ? TAG_XL : (s == 1) ? TAG_GY : (s == 2) ? TAG_HUB : TAG_VRT + 5'(k), d);
    endtask : src
    task automatic chk_stat();
        int         n;
        logic [2:0] f;
        n = mq.size();
        f = {n >= lim() - 1, m_ovr, n >= int'(m_wm)};
        chk_rd(ADDR_STAT_LO, n[7:0]);
        chk_rd(ADDR_STAT_HI, {f[0], f[1], f[2], 4'h0, n[8]});
        `CHK(irq1, |(f & m_irq1[2:0]))
        `CHK(irq2, |(f & m_irq2[2:0]))
    endtask : chk_stat
    task automatic pop();
        logic [55:0] e;
        logic [7:0]  g;
        e = mq.pop_front();
        sbf_host_model_inst.rd(ADDR_TAG, g);
        `CHK(g, e[55:48])
        for (int i = 0; i < 6; i++) begin
            sbf_host_model_inst.rd(ADDR_X_LOW + 8'(i), g);
            `CHK(g, e[8*i +: 8])
        end
        m_ovr = 1'b0;
    endtask : pop
    task automatic drain();
        while (mq.size() > 0) pop();
        chk_stat();
    endtask : drain
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    initial begin
        {rst, sv, vk, sd, fus, go, trig} = {1'b1, 58'h0};
        {m_wm, m_cctl, m_rate, m_mode, m_ben, m_irq1, m_irq2, m_ovr} = 57'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (RA[i]) chk_rd(RA[i], RA[i] == ADDR_STAT_HI ? 8'h80 : 8'h00);
        foreach (RW[i]) begin
            d8 = 8'(xs());
            w(RW[i], d8);
            chk_rd(RW[i], d8);
        end
        w(ADDR_INIT, 8'h08);
        chk_rd(ADDR_INIT, 8'h00);
        // Master compression on, runtime off: words must stay raw
        w(ADDR_EMB_EN, 8'h08);
        w(ADDR_RATE, 8'h11);
        w(ADDR_BATCH_EN, 8'h7f);
        w(ADDR_WM, 8'h03);
        w(ADDR_IRQ1, 8'h01);
        w(ADDR_IRQ2, 8'h04);
        w(ADDR_MODE, {5'h0, MODE_STOP_FULL});
        for (int s = 0; s < 11; s++) begin
            src(s < 3 ? s : 3, 3'(s - 3));
            chk_stat();
        end
        @(posedge clk) fus <= 1'b0;
        src(3, 3'h4);
        fus <= 1'b1;
        drain();
        w(ADDR_WM, 8'h05);
        w(ADDR_CCTL, 8'h80);
        repeat (7) src(0, 3'h0);
        chk_stat();
        w(ADDR_MODE, {5'h0, MODE_CONT});
        repeat (3) src(1, 3'h0);
        chk_stat();
        pop();
        chk_stat();
        drain();
        w(ADDR_CCTL, 8'h00);
        w(ADDR_MODE, {5'h0, MODE_STOP_FULL});
        repeat (258) src(int'(xs() & 32'h1), 3'h0);
        chk_stat();
        drain();
        w(ADDR_CCTL, 8'h08);
        w(ADDR_RATE, 8'h11);
        src(0, 3'h0);
        drain();
        // Second pass holds the trigger high so two-phase modes switch over
        for (int m = 0; m < 16; m++) begin
            @(posedge clk) trig <= m[3];
            w(ADDR_MODE, 8'(m[2:0]));
            chk_rd(ADDR_MODE, 8'(m[2:0]));
            src(0, 3'h0);
            drain();
        end
        finish_test();
    end
endmodule : tb

bind sbf_batch_queue sbf_batch_queue_props sbf_batch_queue_props_inst (.i_ref_clk, .i_sys_rst, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_xl_valid, .i_gy_valid, .i_xl2_valid, .i_hub_valid,
    .i_virt_valid, .o_irq1, .o_irq2);
